// [hw/phwm_pkg.sv]
package phwm_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam logic [7:0] ADDR_SHUNT_MAX = 8'h07;
  localparam logic [7:0] ADDR_SHUNT_MIN = 8'h08;
  localparam logic [7:0] ADDR_BUS_TOP = 8'h09;
  localparam logic [7:0] ADDR_BUS_BOTTOM = 8'h0A;
  localparam logic [7:0] ADDR_POWER_MAX = 8'h0B;
  localparam logic [7:0] ADDR_SHUNT_UPPER = 8'h0C;
  localparam logic [7:0] ADDR_SHUNT_LOWER = 8'h0D;
  localparam logic [7:0] ADDR_POWER_WARN = 8'h0E;
  localparam logic [7:0] ADDR_BUS_HIGH = 8'h0F;
  localparam logic [7:0] ADDR_BUS_LOW = 8'h10;
  localparam logic [7:0] ADDR_CRIT_NEG = 8'h15;
  localparam logic [15:0] RST_SHUNT_MAX = 16'h8000;
  localparam logic [15:0] RST_SHUNT_MIN = 16'h7FFF;
  localparam logic [15:0] RST_BUS_TOP = 16'h0000;
  localparam logic [15:0] RST_BUS_BOTTOM = 16'hFFF8;
  localparam logic [15:0] RST_POWER_MAX = 16'h0000;
  localparam logic [15:0] RST_LIMIT = 16'h0000;
  localparam logic [15:0] BUS_FIELD_MASK = 16'hFFF8;
  localparam logic [15:0] BUS_HIGH_WR_MASK = 16'hFFFB;
  localparam int unsigned CLEAR_BIT = 0;
  localparam int unsigned POL_BIT = 1;
  localparam int unsigned LATCH_BIT = 0;
  localparam int unsigned DELAY_LSB_MS = 100;
  localparam int unsigned DELAY_MAX_STEPS = 15;
  localparam int unsigned DELAY_STEP_CYC = CLK_HZ / 1000 * DELAY_LSB_MS;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] power;
  } phwm_result_t;

  typedef struct packed {
    logic shunt_upper;
    logic shunt_lower;
    logic power;
    logic bus_high;
    logic bus_low;
  } phwm_flags_t;
endpackage

// [hw/phwm_top.sv]
// Function
// - Shunt max register keeps the largest signed shunt result.
// - Shunt max resets to 8000h, most negative code.
// - Shunt min register keeps the smallest signed shunt result.
// - Shunt min resets to 7FFFh, most positive code.
// - Bus top register keeps largest bus field in bits 15..3, resets zero.
// - Bus bottom keeps smallest bus field, resets FFF8h.
// - Power max keeps largest unsigned power result, resets zero.
// - Writing one to bit 0 of a peak register restores its reset value.
// - Shunt above upper limit sets its flag and warning pin when enabled.
// - Shunt below lower limit sets its flag and warning pin when enabled.
// - Shunt limits are signed 16-bit, 10 uV steps.
// - Power above power limit sets its flag and warning pin when enabled.
// - Power limit compare is direct 16-bit unsigned.
// - Bus above high limit sets its flag and warning pin when enabled.
// - Bus below low limit sets its flag and warning pin when enabled.
// - Bus high register bit 1 selects pin polarity, zero is active low.
// - Bus high register bit 0 latches the pin; zero is transparent.
// - Warning delay comes from the critical negative register.
// - Delay field bits 3..0, 0.1 s per step, default zero.
`timescale 1ns/100ps
`default_nettype none
module phwm_top
  import phwm_pkg::*;
(
  input wire logic clk_sys_in, // System clock, 20 MHz.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic reg_wr_in, // Register write strobe.
  input wire logic reg_rd_in, // Register read strobe.
  input wire logic [7:0] reg_addr_in, // Register pointer.
  input wire logic [15:0] reg_wdata_in, // Write data.
  output logic [15:0] reg_rdata_out, // Read data, one cycle after read.
  input wire logic status_rd_in, // Status register read, clears flags.
  input wire logic result_valid_in, // New conversion result pulse.
  input wire phwm_pkg::phwm_result_t result_in, // Conversion results.
  input wire logic warn_output_enable_in, // Warning pin enable.
  output phwm_pkg::phwm_flags_t flags_out, // Sticky warning flags.
  output logic warn_pin_out, // Warning pin level.
  output logic warn_pin_oe_out // Open-drain drive enable.
);
  import phwm_pkg::*;

  logic [15:0] shunt_max_value_q, shunt_min_value_q, bus_top_value_q;
  logic [15:0] bus_bottom_value_q, power_max_value_q;
  logic [15:0] shunt_upper_warn_limit_q, shunt_lower_warn_limit_q;
  logic [15:0] power_warn_limit_field_q, bus_high_warn_limit_q, bus_low_warn_limit_q;
  logic [3:0] warn_output_delay_q;
  logic [15:0] rdata_d;
  phwm_flags_t flags_q, hit_d;
  logic pin_active_q, pin_d;
  logic [31:0] step_cnt_q;
  logic [3:0] delay_cnt_q;

  wire wr_sm = reg_wr_in && reg_addr_in == ADDR_SHUNT_MAX;
  wire wr_sn = reg_wr_in && reg_addr_in == ADDR_SHUNT_MIN;
  wire wr_bt = reg_wr_in && reg_addr_in == ADDR_BUS_TOP;
  wire wr_bb = reg_wr_in && reg_addr_in == ADDR_BUS_BOTTOM;
  wire wr_pm = reg_wr_in && reg_addr_in == ADDR_POWER_MAX;
  wire clr_bit = reg_wdata_in[CLEAR_BIT];
  wire [15:0] bus_f = result_in.bus & BUS_FIELD_MASK;

  // A peak register follows results; a clear write wins since it restarts tracking.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      shunt_max_value_q <= RST_SHUNT_MAX;
      shunt_min_value_q <= RST_SHUNT_MIN;
      bus_top_value_q <= RST_BUS_TOP;
      bus_bottom_value_q <= RST_BUS_BOTTOM;
      power_max_value_q <= RST_POWER_MAX;
    end else begin
      if (wr_sm && clr_bit) begin
        shunt_max_value_q <= RST_SHUNT_MAX;
      end else if (result_valid_in && $signed(result_in.shunt) > $signed(shunt_max_value_q)) begin
        shunt_max_value_q <= result_in.shunt;
      end
      if (wr_sn && clr_bit) begin
        shunt_min_value_q <= RST_SHUNT_MIN;
      end else if (result_valid_in && $signed(result_in.shunt) < $signed(shunt_min_value_q)) begin
        shunt_min_value_q <= result_in.shunt;
      end
      if (wr_bt && clr_bit) begin
        bus_top_value_q <= RST_BUS_TOP;
      end else if (result_valid_in && bus_f > bus_top_value_q) begin
        bus_top_value_q <= bus_f;
      end
      if (wr_bb && clr_bit) begin
        bus_bottom_value_q <= RST_BUS_BOTTOM;
      end else if (result_valid_in && bus_f < bus_bottom_value_q) begin
        bus_bottom_value_q <= bus_f;
      end
      if (wr_pm && clr_bit) begin
        power_max_value_q <= RST_POWER_MAX;
      end else if (result_valid_in && result_in.power > power_max_value_q) begin
        power_max_value_q <= result_in.power;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      shunt_upper_warn_limit_q <= RST_LIMIT;
      shunt_lower_warn_limit_q <= RST_LIMIT;
      power_warn_limit_field_q <= RST_LIMIT;
      bus_high_warn_limit_q <= RST_LIMIT;
      bus_low_warn_limit_q <= RST_LIMIT;
      warn_output_delay_q <= 4'h0;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_SHUNT_UPPER: shunt_upper_warn_limit_q <= reg_wdata_in;
        ADDR_SHUNT_LOWER: shunt_lower_warn_limit_q <= reg_wdata_in;
        ADDR_POWER_WARN: power_warn_limit_field_q <= reg_wdata_in;
        ADDR_BUS_HIGH: bus_high_warn_limit_q <= reg_wdata_in & BUS_HIGH_WR_MASK;
        ADDR_BUS_LOW: bus_low_warn_limit_q <= reg_wdata_in & BUS_FIELD_MASK;
        ADDR_CRIT_NEG: warn_output_delay_q <= reg_wdata_in[3:0];
        default: ;
      endcase
    end
  end

  // Comparisons are made only on a fresh result.
  always_comb begin
    hit_d = '0;
    if (result_valid_in) begin
      hit_d.shunt_upper = $signed(result_in.shunt) > $signed(shunt_upper_warn_limit_q);
      hit_d.shunt_lower = $signed(result_in.shunt) < $signed(shunt_lower_warn_limit_q);
      hit_d.power = result_in.power > power_warn_limit_field_q;
      hit_d.bus_high = bus_f > (bus_high_warn_limit_q & BUS_FIELD_MASK);
      hit_d.bus_low = bus_f < bus_low_warn_limit_q;
    end
  end

  wire any_hit = |hit_d;
  wire latch_en = bus_high_warn_limit_q[LATCH_BIT];
  wire pol_high = bus_high_warn_limit_q[POL_BIT];
  reg cond_q;
  wire step_tick = step_cnt_q == DELAY_STEP_CYC - 1;

  // Flags are sticky; a new hit in the read cycle survives the clear.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      flags_q <= '0;
      cond_q <= 1'b0;
    end else begin
      flags_q <= (status_rd_in ? '0 : flags_q) | hit_d;
      if (result_valid_in) begin
        cond_q <= any_hit;
      end
    end
  end

  // The condition must persist for the delay before the pin asserts.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || !cond_q) begin
      step_cnt_q <= '0;
      delay_cnt_q <= '0;
    end else if (delay_cnt_q < warn_output_delay_q) begin
      step_cnt_q <= step_tick ? '0 : step_cnt_q + 32'd1;
      if (step_tick) begin
        delay_cnt_q <= delay_cnt_q + 4'd1;
      end
    end
  end

  wire delay_done = cond_q && delay_cnt_q >= warn_output_delay_q;
  always_comb begin
    pin_d = delay_done && warn_output_enable_in;
    if (latch_en && pin_active_q && !status_rd_in) begin
      pin_d = warn_output_enable_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pin_active_q <= 1'b0;
      warn_pin_out <= 1'b0;
      warn_pin_oe_out <= 1'b0;
    end else begin
      pin_active_q <= pin_d;
      warn_pin_out <= 1'b0;
      warn_pin_oe_out <= pin_d ^ pol_high;
    end
  end

  always_comb begin
    unique case (reg_addr_in)
      ADDR_SHUNT_MAX: rdata_d = shunt_max_value_q;
      ADDR_SHUNT_MIN: rdata_d = shunt_min_value_q;
      ADDR_BUS_TOP: rdata_d = bus_top_value_q;
      ADDR_BUS_BOTTOM: rdata_d = bus_bottom_value_q;
      ADDR_POWER_MAX: rdata_d = power_max_value_q;
      ADDR_SHUNT_UPPER: rdata_d = shunt_upper_warn_limit_q;
      ADDR_SHUNT_LOWER: rdata_d = shunt_lower_warn_limit_q;
      ADDR_POWER_WARN: rdata_d = power_warn_limit_field_q;
      ADDR_BUS_HIGH: rdata_d = bus_high_warn_limit_q;
      ADDR_BUS_LOW: rdata_d = bus_low_warn_limit_q;
      ADDR_CRIT_NEG: rdata_d = {12'h000, warn_output_delay_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
      flags_out <= '0;
    end else begin
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_d;
      end
      flags_out <= (status_rd_in ? '0 : flags_q) | hit_d;
    end
  end

  property p_shunt_max;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      result_valid_in && !wr_sm && $signed(result_in.shunt) > $signed(shunt_max_value_q)
      |=> shunt_max_value_q == $past(result_in.shunt);
  endproperty
  a_shunt_max: assert property (p_shunt_max) else $error("shunt max missed");
  property p_shunt_min;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !$past(wr_sn) |-> !($signed(shunt_min_value_q) > $signed($past(shunt_min_value_q)));
  endproperty
  a_shunt_min: assert property (p_shunt_min) else $error("shunt min rose");
  property p_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_bb && clr_bit |=> bus_bottom_value_q == RST_BUS_BOTTOM;
  endproperty
  a_clear: assert property (p_clear) else $error("peak clear failed");
  property p_bus_low;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      bus_top_value_q[2:0] == 3'h0 && bus_bottom_value_q[2:0] == 3'h0;
  endproperty
  a_bus_low: assert property (p_bus_low) else $error("bus low bits set");
  property p_flag;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      hit_d.power |=> flags_q.power;
  endproperty
  a_flag: assert property (p_flag) else $error("power flag missed");
  property p_flag_up;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      hit_d.shunt_upper ##1 !status_rd_in |=> flags_q.shunt_upper;
  endproperty
  a_flag_up: assert property (p_flag_up) else $error("flag not sticky");
  property p_pol;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !warn_output_enable_in && !latch_en |=> warn_pin_oe_out == $past(pol_high);
  endproperty
  a_pol: assert property (p_pol) else $error("idle pin sense wrong");
  property p_nodelay;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      cond_q && warn_output_delay_q == 4'h0 && warn_output_enable_in |=> pin_active_q;
  endproperty
  a_nodelay: assert property (p_nodelay) else $error("pin not asserted");
  // Each peak register takes a new extreme result and restores its reset value on a clear.
  property p_shunt_min_take;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      result_valid_in && !wr_sn && $signed(result_in.shunt) < $signed(shunt_min_value_q)
      |=> shunt_min_value_q == $past(result_in.shunt);
  endproperty
  a_shunt_min_take: assert property (p_shunt_min_take) else $error("shunt min missed");
  property p_bus_top_take;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      result_valid_in && !wr_bt && bus_f > bus_top_value_q
      |=> bus_top_value_q == $past(bus_f);
  endproperty
  a_bus_top_take: assert property (p_bus_top_take) else $error("bus top missed");
  property p_bus_bottom_take;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      result_valid_in && !wr_bb && bus_f < bus_bottom_value_q
      |=> bus_bottom_value_q == $past(bus_f);
  endproperty
  a_bus_bottom_take: assert property (p_bus_bottom_take) else $error("bus bottom missed");
  property p_power_max_take;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      result_valid_in && !wr_pm && result_in.power > power_max_value_q
      |=> power_max_value_q == $past(result_in.power);
  endproperty
  a_power_max_take: assert property (p_power_max_take) else $error("power max missed");
  property p_shunt_max_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_sm && clr_bit |=> shunt_max_value_q == RST_SHUNT_MAX;
  endproperty
  a_shunt_max_clear: assert property (p_shunt_max_clear) else $error("shunt max clear");
  property p_shunt_min_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_sn && clr_bit |=> shunt_min_value_q == RST_SHUNT_MIN;
  endproperty
  a_shunt_min_clear: assert property (p_shunt_min_clear) else $error("shunt min clear");
  property p_top_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_bt && clr_bit |=> bus_top_value_q == RST_BUS_TOP;
  endproperty
  a_top_clear: assert property (p_top_clear) else $error("bus top clear failed");
  property p_power_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_pm && clr_bit |=> power_max_value_q == RST_POWER_MAX;
  endproperty
  a_power_clear: assert property (p_power_clear) else $error("power clear failed");
  property p_flag_lower;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      hit_d.shunt_lower |=> flags_q.shunt_lower;
  endproperty
  a_flag_lower: assert property (p_flag_lower) else $error("lower flag missed");
  property p_flag_bus_high;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      hit_d.bus_high |=> flags_q.bus_high;
  endproperty
  a_flag_bus_high: assert property (p_flag_bus_high) else $error("bus high flag missed");
  property p_flag_bus_low;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      hit_d.bus_low |=> flags_q.bus_low;
  endproperty
  a_flag_bus_low: assert property (p_flag_bus_low) else $error("bus low flag missed");
  property p_flag_keep;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !result_valid_in && !status_rd_in |=> flags_q == $past(flags_q);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flags moved without result");
  property p_status_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      status_rd_in && !result_valid_in |=> flags_q == '0;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("flags not cleared");
  property p_limit_read;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == ADDR_SHUNT_UPPER
      |=> reg_rdata_out == $past(shunt_upper_warn_limit_q);
  endproperty
  a_limit_read: assert property (p_limit_read) else $error("limit read wrong");
  property p_limit_bits;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      bus_high_warn_limit_q[2] == 1'b0 && bus_low_warn_limit_q[2:0] == 3'h0;
  endproperty
  a_limit_bits: assert property (p_limit_bits) else $error("unused limit bits set");
  property p_delay_hold;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !pin_active_q && !delay_done |=> !pin_active_q;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("pin before delay end");
  property p_latch_hold;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      latch_en && pin_active_q && !status_rd_in && warn_output_enable_in |=> pin_active_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched pin dropped");
  property p_transparent;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !latch_en && !cond_q |=> !pin_active_q;
  endproperty
  a_transparent: assert property (p_transparent) else $error("pin held while clear");
  property p_oe_sense;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      warn_pin_oe_out == (pin_active_q ^ $past(pol_high));
  endproperty
  a_oe_sense: assert property (p_oe_sense) else $error("pin drive sense wrong");
endmodule
`default_nettype wire

// [dv/phwm_host.sv]
`timescale 1ns/100ps
`default_nettype none
module phwm_host (
  input wire logic clk_sys_in, // System clock.
  input wire logic [15:0] reg_rdata_in, // Read data from the device.
  output logic reg_wr_out, // Write strobe.
  output logic reg_rd_out, // Read strobe.
  output logic [7:0] reg_addr_out, // Register pointer.
  output logic [15:0] reg_wdata_out, // Write data.
  output logic status_rd_out // Status register read pulse.
);
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
    status_rd_out = 1'b0;
  end
  // Released lines show the inverse so stale values are never mistaken for data.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    #1 d = reg_rdata_in;
  endtask
  // A one in bit 0 restarts peak tracking of that register.
  task automatic clear_peak(input logic [7:0] a);
    wr(a, 16'h0001);
  endtask
  task automatic status_read();
    @(posedge clk_sys_in);
    status_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    status_rd_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import phwm_pkg::*;
  logic clk, rst_n, wr, rd, st_rd, vld, wen, pin, oe;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, d;
  phwm_result_t res;
  phwm_flags_t flags;
  int miscompares = 0;
  int checks = 0;
  // Each row: write flag, address, write data, expected read value.
  logic [40:0] rows [22] = '{41'h0_07_0000_8000, 41'h0_08_0000_7FFF, 41'h0_09_0000_0000,
    41'h0_0A_0000_FFF8, 41'h0_0B_0000_0000, 41'h0_0C_0000_0000, 41'h0_0D_0000_0000,
    41'h0_0E_0000_0000, 41'h0_0F_0000_0000, 41'h0_10_0000_0000, 41'h0_15_0000_0000,
    41'h1_20_FFFF_0000, 41'h1_09_FFFE_0000, 41'h1_0F_FFFF_FFFB, 41'h1_10_FFFF_FFF8,
    41'h1_15_FFFF_000F, 41'h1_15_0000_0000, 41'h1_0C_0200_0200, 41'h1_0D_FE00_FE00,
    41'h1_0E_0300_0300, 41'h1_0F_0400_0400, 41'h1_10_0040_0040};
  logic [15:0] pk_exp [5] = '{16'h0100, 16'hFF00, 16'h0108, 16'h0050, 16'h0200};
  logic [15:0] pk_rst [5] = '{RST_SHUNT_MAX, RST_SHUNT_MIN, RST_BUS_TOP, RST_BUS_BOTTOM,
    RST_POWER_MAX};
  phwm_top i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .status_rd_in(st_rd),
    .result_valid_in(vld), .result_in(res), .warn_output_enable_in(wen), .flags_out(flags),
    .warn_pin_out(pin), .warn_pin_oe_out(oe));
  phwm_host i_host (.clk_sys_in(clk), .reg_rdata_in(rdata), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .status_rd_out(st_rd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    i_host.rd(a, d);
    check(d, exp);
  endtask
  task automatic send(input logic [15:0] s, input logic [15:0] b, input logic [15:0] p);
    @(posedge clk);
    vld <= 1'b1;
    res <= {s, b, p};
    @(posedge clk);
    vld <= 1'b0;
    res <= ~{s, b, p};
  endtask
  // Flags settle on the edge that takes the result, the pin drive one edge later.
  task automatic fo(input logic [4:0] f, input logic o);
    #1 check({11'h000, flags}, {11'h000, f});
    @(posedge clk);
    #1 check({15'h0000, oe}, {15'h0000, o});
    check({15'h0000, pin}, 16'h0000);
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    vld = 1'b0;
    res = '0;
    wen = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][40]) i_host.wr(rows[i][39:32], rows[i][31:16]);
      rdchk(rows[i][39:32], rows[i][15:0]);
    end
    $display("test register table done");
    i_host.status_read();
    send(16'h0100, 16'h0108, 16'h0200);
    fo(5'b00000, 1'b0);
    send(16'hFF00, 16'h0050, 16'h0100);
    fo(5'b00000, 1'b0);
    foreach (pk_exp[i]) rdchk(ADDR_SHUNT_MAX + 8'(i), pk_exp[i]);
    foreach (pk_rst[i]) begin
      i_host.clear_peak(ADDR_SHUNT_MAX + 8'(i));
      rdchk(ADDR_SHUNT_MAX + 8'(i), pk_rst[i]);
    end
    $display("test peaks done");
    send(16'h0300, 16'h0100, 16'h0100);
    fo(5'b10000, 1'b1);
    i_host.status_read();
    send(16'hFD00, 16'h0500, 16'h0400);
    fo(5'b01110, 1'b1);
    i_host.status_read();
    send(16'h0200, 16'h0400, 16'h0300);
    fo(5'b00000, 1'b0);
    send(16'h0000, 16'h0020, 16'h0000);
    fo(5'b00001, 1'b1);
    $display("test warnings done");
    send(16'h0200, 16'h0400, 16'h0300);
    fo(5'b00001, 1'b0);
    i_host.wr(ADDR_BUS_HIGH, 16'h0403);
    i_host.status_read();
    send(16'h0200, 16'h0400, 16'h0300);
    fo(5'b00000, 1'b1);
    send(16'h0300, 16'h0400, 16'h0300);
    fo(5'b10000, 1'b0);
    send(16'h0200, 16'h0400, 16'h0300);
    fo(5'b10000, 1'b0);
    i_host.status_read();
    repeat (3) @(posedge clk);
    #1 check({15'h0000, oe}, 16'h0001);
    i_host.wr(ADDR_BUS_HIGH, 16'h0400);
    wen <= 1'b0;
    i_host.status_read();
    send(16'h0300, 16'h0400, 16'h0300);
    fo(5'b10000, 1'b0);
    @(posedge clk);
    wen <= 1'b1;
    $display("test pin modes done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 check({11'h000, flags}, 16'h0000);
    rdchk(ADDR_SHUNT_MAX, RST_SHUNT_MAX);
    rdchk(ADDR_SHUNT_UPPER, RST_LIMIT);
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
